// File: core/ffir_regs.sv
// Data FIFO, input-sense and rate-control registers behind an APB slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module ffir_regs #(
  parameter int DEPTH = 16
) (
  // Clock, reset and enable
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ffir_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [7:0] lane_drive_o,
  // Personality strap
  input wire logic [1:0] personality_i,
  // Command engine side
  input wire ffir_pkg::ffir_phase_t phase_i,
  input wire logic exec_read_i,
  input wire ffir_pkg::ffir_eng_in_t eng_i,
  input wire ffir_pkg::ffir_cfg_t cfg_i,
  input wire logic soft_reset_i,
  input wire logic dma_gate_enable_i,
  output logic [ffir_pkg::DATA_W-1:0] eng_data_o,
  output logic eng_avail_o,
  output logic eng_space_o,
  output logic svc_req_o,
  output logic terminate_o,
  // Transfer status
  output logic host_transfer_permit_o,
  output logic transfer_direction_o,
  // Drive cable and rate
  input wire logic media_changed_i,
  output logic density_select_pin_o,
  output logic [1:0] rate_code_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  // Elaboration check on FIFO depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 16)
  begin : g_depth_bad
    $error("ffir_regs: DEPTH must be a power of two from 2 to 16");
  end

  // Synchroniser stages for pins
  logic chg_s1;
  logic chg_s2;
  logic [1:0] pers_s1;
  logic [1:0] pers_s2;

  // APB handshake
  logic acc;
  logic ack_q;
  logic done;
  logic [ffir_pkg::IDX_W-1:0] idx;
  logic is_cfg;
  logic is_status;
  logic is_data;
  logic is_sense;
  logic mapped;
  logic refused;
  logic [7:0] rd_val;
  logic [7:0] lanes_val;

  // FIFO storage and state
  logic [ffir_pkg::DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] cap;
  logic [CNT_W-1:0] thresh_bytes;
  logic full;
  logic empty;
  logic push;
  logic pop;
  logic clear;
  logic [ffir_pkg::DATA_W-1:0] push_data;
  logic host_wr;
  logic host_rd;
  logic dir;
  logic permit;
  logic in_exec;
  ffir_pkg::ffir_phase_t phase_q;

  // Control registers
  logic fifo_en;
  logic [3:0] thresh;
  logic [1:0] rate;
  logic precomp_off_shadow;
  logic density;
  logic [1:0] force_media_change_field;
  logic ovr_flag;
  logic xrun;
  logic rate_wr;
  logic ccr_wr;
  logic dsr_wr;
  logic media_changed;
  logic low_density_flag;

  // Two-stage synchronisers for cable pin and personality strap
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      chg_s1 <= 1'b0;
      chg_s2 <= 1'b0;
      pers_s1 <= 2'h0;
      pers_s2 <= 2'h0;
    end
    else if (ce_i)
    begin
      chg_s1 <= media_changed_i;
      chg_s2 <= chg_s1;
      pers_s1 <= personality_i;
      pers_s2 <= pers_s1;
    end
  end

  // Access phase gets one wait state; commit happens with pready
  assign acc = psel_i & penable_i & ce_i;
  assign done = acc & ack_q;
  assign pready_o = done;
  assign idx = paddr_i[ffir_pkg::ADDR_W-1:ffir_pkg::IDX_LSB];

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_q <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_q <= acc & ~ack_q;
    end
  end

  // Address decode
  always_comb
  begin
    is_cfg = 1'b0;
    is_status = 1'b0;
    is_data = 1'b0;
    is_sense = 1'b0;
    if (idx == ffir_pkg::IDX_CFG)
    begin
      is_cfg = 1'b1;
    end
    else if (idx == ffir_pkg::IDX_STATUS)
    begin
      is_status = 1'b1;
    end
    else if (idx == ffir_pkg::IDX_DATA)
    begin
      is_data = 1'b1;
    end
    else if (idx == ffir_pkg::IDX_SENSE)
    begin
      is_sense = 1'b1;
    end
  end

  assign mapped = is_cfg | is_status | is_data | is_sense;

  // Data access out of turn is refused with an error answer
  assign refused = is_data & (~permit | (pwrite_i == dir));
  assign pslverr_o = done & (~mapped | refused);

  // Transfer direction and permission
  assign in_exec = (phase_i == ffir_pkg::PH_EXEC);
  always_comb
  begin
    case (phase_i)
      ffir_pkg::PH_EXEC: dir = exec_read_i;
      ffir_pkg::PH_RESULT: dir = 1'b1;
      default: dir = 1'b0;
    endcase
  end

  assign full = (count >= cap);
  assign empty = (count == '0);
  assign permit = dir ? ~empty : ~full;
  assign host_transfer_permit_o = permit;
  assign transfer_direction_o = dir;

  // Single byte outside execution or with FIFO off
  assign cap = (in_exec && fifo_en) ? CNT_FULL : CNT_ONE;
  assign thresh_bytes = fifo_en ? (CNT_W'(thresh) + CNT_ONE) : CNT_ONE;

  // Host and engine share the FIFO, the side chosen by direction
  assign host_wr = done & is_data & pwrite_i & pstrb_i[0] & permit & ~dir;
  assign host_rd = done & is_data & ~pwrite_i & permit & dir;
  assign push = dir ? (eng_i.push & ~full) : host_wr;
  assign pop = dir ? host_rd : (eng_i.take & ~empty);
  assign push_data = dir ? eng_i.data : pwdata_i[ffir_pkg::DATA_W-1:0];

  // Empty on execution entry and on soft reset
  assign clear = (in_exec & (phase_q != ffir_pkg::PH_EXEC)) | soft_reset_i;

  // Overrun: engine push when full; underrun: engine take when empty
  assign xrun = in_exec & ((dir & eng_i.push & full) | (~dir & eng_i.take & empty));

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      phase_q <= ffir_pkg::PH_IDLE;
    end
    else if (ce_i)
    begin
      phase_q <= phase_i;
    end
  end

  // FIFO storage
  always_ff @(posedge clock_i)
  begin
    if (ce_i && push && !clear)
    begin
      mem[wr_ptr] <= push_data;
    end
  end

  // FIFO pointers and level
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else if (ce_i)
    begin
      if (clear || xrun)
      begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
      end
      else
      begin
        if (push)
        begin
          wr_ptr <= wr_ptr + PTR_W'(1);
        end
        if (pop)
        begin
          rd_ptr <= rd_ptr + PTR_W'(1);
        end
        if (push && !pop)
        begin
          count <= count + CNT_ONE;
        end
        else if (pop && !push)
        begin
          count <= count - CNT_ONE;
        end
      end
    end
  end

  // Engine view of the FIFO
  assign eng_data_o = mem[rd_ptr];
  assign eng_avail_o = ~dir & ~empty;
  assign eng_space_o = dir & ~full;

  // Service request at threshold during execution
  assign svc_req_o = in_exec & (dir ? (count >= thresh_bytes)
                                    : ((cap - count) >= thresh_bytes));

  // Terminate pulse towards the command engine
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      terminate_o <= 1'b0;
    end
    else if (ce_i)
    begin
      terminate_o <= xrun;
    end
  end

  // Sticky overrun flag, set wins over write-one clear
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ovr_flag <= 1'b0;
    end
    else if (ce_i)
    begin
      if (xrun)
      begin
        ovr_flag <= 1'b1;
      end
      else if (done && is_status && pwrite_i && pstrb_i[0] && pwdata_i[ffir_pkg::STS_OVR])
      begin
        ovr_flag <= 1'b0;
      end
    end
  end

  // FIFO mode, threshold control
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fifo_en <= 1'b0;
      thresh <= 4'h0;
    end
    else if (ce_i)
    begin
      if (soft_reset_i)
      begin
        fifo_en <= 1'b0;
      end
      else if (cfg_i.load)
      begin
        fifo_en <= cfg_i.fifo_en;
        thresh <= cfg_i.thresh;
      end
    end
  end

  // Rate writes from either rate register
  assign ccr_wr = done & is_sense & pwrite_i & pstrb_i[0];
  assign dsr_wr = done & is_status & pwrite_i & pstrb_i[0];
  assign rate_wr = ccr_wr | dsr_wr;

  // Rate code: hardware reset only, soft reset leaves it
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rate <= ffir_pkg::RATE_RST;
    end
    else if (ce_i && rate_wr)
    begin
      rate <= pwdata_i[ffir_pkg::RATE_LSB +: 2];
    end
  end

  assign rate_code_o = rate;
  assign low_density_flag = (rate == ffir_pkg::RATE_250K) || (rate == ffir_pkg::RATE_300K);

  // Precompensation-off shadow, kept in the third layout only
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      precomp_off_shadow <= 1'b0;
    end
    else if (ce_i && ccr_wr && pers_s2 == ffir_pkg::PERS_THIRD)
    begin
      precomp_off_shadow <= pwdata_i[ffir_pkg::SNS_PRECOMP];
    end
  end

  // Density select pin follows the latest rate write
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      density <= ffir_pkg::DENSITY_RST;
    end
    else if (ce_i && rate_wr)
    begin
      density <= (pwdata_i[ffir_pkg::RATE_LSB +: 2] == ffir_pkg::RATE_500K)
        || (pwdata_i[ffir_pkg::RATE_LSB +: 2] == ffir_pkg::RATE_1M);
    end
  end

  assign density_select_pin_o = density;

  // Force media-change field
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      force_media_change_field <= 2'h0;
    end
    else if (ce_i && done && is_cfg && pwrite_i && pstrb_i[0])
    begin
      force_media_change_field <= pwdata_i[1:0];
    end
  end

  assign media_changed = force_media_change_field[ffir_pkg::FRC_EN]
    ? force_media_change_field[ffir_pkg::FRC_VAL] : ~chg_s2;

  // Read value and driven lanes per register and personality
  always_comb
  begin
    rd_val = 8'h00;
    lanes_val = ffir_pkg::LANES_ALL;
    if (is_sense)
    begin
      case (pers_s2)
        ffir_pkg::PERS_SECOND:
          rd_val = {media_changed, ffir_pkg::SNS_ONES, rate, low_density_flag};
        ffir_pkg::PERS_THIRD:
          rd_val = {media_changed, ffir_pkg::SNS_ZEROS, dma_gate_enable_i,
                    precomp_off_shadow, rate};
        default:
        begin
          rd_val = {media_changed, ffir_pkg::SNS_AT_LOW};
          lanes_val = ffir_pkg::LANES_AT;
        end
      endcase
    end
    else if (is_status)
    begin
      rd_val[ffir_pkg::STS_PERMIT] = permit;
      rd_val[ffir_pkg::STS_DIR] = dir;
      rd_val[ffir_pkg::STS_EXEC] = in_exec;
      rd_val[ffir_pkg::STS_BUSY] = (phase_i != ffir_pkg::PH_IDLE);
      rd_val[ffir_pkg::STS_OVR] = ovr_flag;
      rd_val[ffir_pkg::STS_FIFO_EN] = fifo_en;
    end
    else if (is_data)
    begin
      rd_val = mem[rd_ptr];
    end
    else if (is_cfg)
    begin
      rd_val = {6'h00, force_media_change_field};
    end
  end

  // Read data captured in the first access cycle
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prdata_o <= 32'h0000_0000;
      lane_drive_o <= ffir_pkg::LANES_ALL;
    end
    else if (ce_i && acc && !ack_q && !pwrite_i)
    begin
      prdata_o <= {24'h00_0000, rd_val};
      lane_drive_o <= lanes_val;
    end
  end

endmodule

// File: core/ffir_pkg.sv
// Shared constants and carrier types for the floppy FIFO, input-sense and rate-control block
package ffir_pkg;

  // Bus geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CFG = 10'h3f0;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h3f4;
  localparam logic [IDX_W-1:0] IDX_DATA = 10'h3f5;
  localparam logic [IDX_W-1:0] IDX_SENSE = 10'h3f7;

  // Data-rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_RST = RATE_250K;
  localparam logic DENSITY_RST = 1'b1;

  // Status register fields
  localparam int STS_PERMIT = 7;
  localparam int STS_DIR = 6;
  localparam int STS_EXEC = 5;
  localparam int STS_BUSY = 4;
  localparam int STS_OVR = 3;
  localparam int STS_FIFO_EN = 2;

  // Input-sense and rate-control fields
  localparam int SNS_CHG = 7;
  localparam int SNS_PRECOMP = 2;
  localparam int RATE_LSB = 0;
  localparam logic [3:0] SNS_ONES = 4'hf;
  localparam logic [2:0] SNS_ZEROS = 3'h0;
  localparam logic [6:0] SNS_AT_LOW = 7'h00;
  localparam logic [7:0] LANES_ALL = 8'hff;
  localparam logic [7:0] LANES_AT = 8'h80;

  // Force media-change field in the configuration register
  localparam int FRC_VAL = 0;
  localparam int FRC_EN = 1;

  // Register personalities
  typedef enum logic [1:0] {
    PERS_AT = 2'h0,
    PERS_SECOND = 2'h1,
    PERS_THIRD = 2'h2
  } ffir_pers_t;

  // Controller phase, Gray ordered along the command sequence
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_EXEC = 2'b11,
    PH_RESULT = 2'b10
  } ffir_phase_t;

  // Byte traffic from the command engine
  typedef struct packed {
    logic push;
    logic take;
    logic [DATA_W-1:0] data;
  } ffir_eng_in_t;

  // Configure command outcome
  typedef struct packed {
    logic load;
    logic fifo_en;
    logic [3:0] thresh;
  } ffir_cfg_t;

endpackage

// File: test/ffir_regs_properties.sv
// Port-level checks for the floppy FIFO, sense and rate register block
`timescale 1ns/10ps
module ffir_regs_properties (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ffir_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] lane_drive_o,
  // Controller side
  input wire logic [1:0] personality_i,
  input wire ffir_pkg::ffir_phase_t phase_i,
  input wire logic soft_reset_i,
  input wire logic dma_gate_enable_i,
  input wire logic eng_avail_o,
  input wire logic terminate_o,
  input wire logic host_transfer_permit_o,
  input wire logic transfer_direction_o,
  input wire logic density_select_pin_o,
  input wire logic [1:0] rate_code_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  // Finished sense reads and rate writes
  logic sns_rd;
  logic rate_wr;
  assign sns_rd = pready_o && !pwrite_i && paddr_i[11:2] == ffir_pkg::IDX_SENSE;
  assign rate_wr = pready_o && pwrite_i && !pslverr_o && pstrb_i[0]
    && paddr_i[11:2] inside {ffir_pkg::IDX_SENSE, ffir_pkg::IDX_STATUS};
  // Setup followed by first access cycle
  sequence s_access;
    psel_i && !penable_i ##1 psel_i && penable_i && ce_i;
  endsequence
  property p_ready;
    s_access |-> !pready_o ##1 (!ce_i || pready_o);
  endproperty
  a_ready: assert property (p_ready) else $error("pready not after one wait");
  property p_err;
    pslverr_o |-> pready_o;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_cmd;
    phase_i == ffir_pkg::PH_CMD && host_transfer_permit_o |-> !transfer_direction_o;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command phase read direction");
  property p_rate;
    rate_wr |=> rate_code_o == $past(pwdata_i[1:0])
      && density_select_pin_o == ($past(pwdata_i[1]) == $past(pwdata_i[0]));
  endproperty
  a_rate: assert property (p_rate) else $error("rate write not applied");
  property p_soft;
    soft_reset_i && !rate_wr |=> $stable(rate_code_o) && $stable(density_select_pin_o);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset moved rate");
  property p_at;
    sns_rd && personality_i inside {2'h0, 2'h3}
      |-> lane_drive_o == ffir_pkg::LANES_AT && prdata_o[6:0] == ffir_pkg::SNS_AT_LOW;
  endproperty
  a_at: assert property (p_at) else $error("first layout lanes wrong");
  property p_sec;
    sns_rd && personality_i == 2'h1 |-> lane_drive_o == ffir_pkg::LANES_ALL
      && prdata_o[6:0] == {ffir_pkg::SNS_ONES, rate_code_o, ^rate_code_o};
  endproperty
  a_sec: assert property (p_sec) else $error("second layout wrong");
  property p_thr;
    sns_rd && personality_i == 2'h2 |-> prdata_o[1:0] == rate_code_o
      && prdata_o[6:3] == {ffir_pkg::SNS_ZEROS, dma_gate_enable_i};
  endproperty
  a_thr: assert property (p_thr) else $error("third layout wrong");
  property p_term;
    terminate_o |-> $past(phase_i) == ffir_pkg::PH_EXEC ##1 !terminate_o;
  endproperty
  a_term: assert property (p_term) else $error("terminate pulse wrong");
  property p_exec;
    phase_i == ffir_pkg::PH_EXEC && $past(phase_i) != ffir_pkg::PH_EXEC
      && !(pready_o && pwrite_i) |=> !eng_avail_o;
  endproperty
  a_exec: assert property (p_exec) else $error("FIFO kept on execution entry");
endmodule

bind ffir_regs ffir_regs_properties u_props (.clock_i(clock_i), .rstn_i(rstn_i),
  .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .lane_drive_o(lane_drive_o),
  .personality_i(personality_i), .phase_i(phase_i), .soft_reset_i(soft_reset_i),
  .dma_gate_enable_i(dma_gate_enable_i), .eng_avail_o(eng_avail_o),
  .terminate_o(terminate_o), .host_transfer_permit_o(host_transfer_permit_o),
  .transfer_direction_o(transfer_direction_o),
  .density_select_pin_o(density_select_pin_o), .rate_code_o(rate_code_o));

// File: test/ffir_host.sv
// Host processor model issuing one APB access at a time
`timescale 1ns/10ps
module ffir_host (
  // Clock
  input wire logic clock_i,
  // APB master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  // Idle bus at time zero
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    pstrb_o = 4'h1;
  end
  // Setup, access, wait for ready, then release
  task automatic acc(input logic [11:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge clock_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= {24'h0, d};
    @(posedge clock_i);
    penable_o <= 1'b1;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clock_i);
      ok = pready_i;
      rd = prdata_i[7:0];
      err = pslverr_i;
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// File: test/ffir_regs_bench.sv
// Self-checking bench for the floppy FIFO, sense and rate registers
`timescale 1ns/10ps
module ffir_regs_bench;
  localparam logic [11:0] A_SNS = {ffir_pkg::IDX_SENSE, 2'h0};
  localparam logic [11:0] A_DAT = {ffir_pkg::IDX_DATA, 2'h0};
  localparam logic [11:0] A_STS = {ffir_pkg::IDX_STATUS, 2'h0};
  localparam logic [11:0] A_CFG = {ffir_pkg::IDX_CFG, 2'h0};
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] lanes, eng_data, rv;
  logic [1:0] pers = 2'h1;
  logic [1:0] rate, rc;
  ffir_pkg::ffir_phase_t phase = ffir_pkg::PH_IDLE;
  ffir_pkg::ffir_eng_in_t eng = '0;
  ffir_pkg::ffir_cfg_t cfg = '0;
  logic exec_rd = 1'b0;
  logic srst = 1'b0;
  logic dma = 1'b0;
  logic ce = 1'b1;
  logic chg = 1'b0;
  logic avail, svc, term, permit, dens;
  logic saw_term = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  // Clock and devices
  always #2.5 clock_i = ~clock_i;
  ffir_regs #(.DEPTH(4)) u_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .lane_drive_o(lanes), .personality_i(pers),
    .phase_i(phase), .exec_read_i(exec_rd), .eng_i(eng), .cfg_i(cfg), .soft_reset_i(srst),
    .dma_gate_enable_i(dma), .eng_data_o(eng_data), .eng_avail_o(avail), .eng_space_o(),
    .svc_req_o(svc), .terminate_o(term), .host_transfer_permit_o(permit),
    .transfer_direction_o(), .density_select_pin_o(dens), .rate_code_o(rate),
    .media_changed_i(chg));
  ffir_host u_host (.clock_i(clock_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));
  // Catch the one-cycle terminate pulse
  always @(posedge clock_i)
    if (term === 1'b1)
      saw_term <= 1'b1;
  // Verdict and end of run
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Byte comparison
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus access with timeout
  task automatic acc(input logic [11:0] a, input logic w, input logic [7:0] d);
    u_host.acc(a, w, d, rv, er, ok);
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD pready expected 1 seen %b", ok);
      final_report();
    end
  endtask
  // Engine byte traffic, n consecutive cycles
  task automatic engine(input int n, input logic p, input logic [7:0] d);
    for (int i = 0; i < n; i++)
    begin
      eng <= {p, !p, d + 8'(i)};
      @(posedge clock_i);
    end
    eng <= '0;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    cmp("rate", {6'h0, ffir_pkg::RATE_RST}, {6'h0, rate});
    cmp("dens", 8'h01, {7'h0, dens});
    acc(A_SNS, 1'b0, 8'h00);
    cmp("sense", 8'hfd, rv);
    for (int r = 0; r < 4; r++)
    begin
      rc = 2'(r);
      acc(A_SNS, 1'b1, {6'h0, rc});
      acc(A_SNS, 1'b0, 8'h00);
      cmp("sense", {5'h1f, rc, ^rc}, rv);
      cmp("dens", {7'h0, rc[1] == rc[0]}, {7'h0, dens});
    end
    acc(A_STS, 1'b1, 8'h01);
    srst <= 1'b1;
    @(posedge clock_i);
    srst <= 1'b0;
    @(posedge clock_i);
    cmp("rate", 8'h01, {6'h0, rate});
    cmp("dens", 8'h00, {7'h0, dens});
    $display("test rates done");
    pers <= 2'h2;
    dma <= 1'b1;
    chg <= 1'b1;
    acc(A_SNS, 1'b1, 8'h06);
    acc(A_SNS, 1'b0, 8'h00);
    cmp("third", 8'h0e, rv);
    srst <= 1'b1;
    @(posedge clock_i);
    srst <= 1'b0;
    acc(A_CFG, 1'b1, 8'h03);
    acc(A_SNS, 1'b0, 8'h00);
    cmp("third", 8'h8e, rv);
    pers <= 2'h0;
    acc(A_CFG, 1'b1, 8'h00);
    acc(A_SNS, 1'b0, 8'h00);
    cmp("at", 8'h00, rv);
    cmp("lanes", ffir_pkg::LANES_AT, lanes);
    $display("test sense done");
    acc(A_DAT, 1'b1, 8'h5a);
    @(negedge clock_i);
    cmp("permit", 8'h00, {7'h0, permit});
    cmp("eng", 8'h5a, eng_data);
    acc(A_DAT, 1'b1, 8'h11);
    cmp("err", 8'h01, {7'h0, er});
    acc(12'h000, 1'b0, 8'h00);
    cmp("err", 8'h01, {7'h0, er});
    cfg <= {1'b1, 1'b1, 4'h1};
    @(posedge clock_i);
    cfg <= '0;
    phase <= ffir_pkg::PH_CMD;
    acc(A_DAT, 1'b1, 8'h22);
    cmp("err", 8'h01, {7'h0, er});
    phase <= ffir_pkg::PH_EXEC;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    cmp("avail", 8'h00, {7'h0, avail});
    $display("test data done");
    @(posedge clock_i);
    exec_rd <= 1'b1;
    @(posedge clock_i);
    engine(2, 1'b1, 8'h30);
    cmp("svc", 8'h01, {7'h0, svc});
    acc(A_STS, 1'b0, 8'h00);
    cmp("status", 8'hc4, rv & 8'hc4);
    acc(A_DAT, 1'b0, 8'h00);
    cmp("fifo", 8'h30, rv);
    acc(A_DAT, 1'b0, 8'h00);
    cmp("fifo", 8'h31, rv);
    engine(5, 1'b1, 8'h40);
    cmp("term", 8'h01, {7'h0, saw_term});
    acc(A_STS, 1'b0, 8'h00);
    cmp("ovr", 8'h08, rv & 8'h08);
    srst <= 1'b1;
    @(posedge clock_i);
    srst <= 1'b0;
    acc(A_STS, 1'b0, 8'h00);
    cmp("fifo_en", 8'h00, rv & 8'h04);
    $display("test fifo done");
    ce <= 1'b0;
    engine(2, 1'b1, 8'h50);
    @(posedge clock_i);
    ce <= 1'b1;
    @(negedge clock_i);
    cmp("frozen", 8'h00, {7'h0, permit});
    @(posedge clock_i);
    phase <= ffir_pkg::PH_IDLE;
    acc(A_SNS, 1'b1, 8'h01);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    cmp("rate", {6'h0, ffir_pkg::RATE_RST}, {6'h0, rate});
    cmp("dens", 8'h01, {7'h0, dens});
    $display("test reset done");
    final_report();
  end
endmodule
